// file: hw/osg_pkg.sv
// shared constants, command codes and carriers of the operation status group
package osg_pkg;

	// ****************************************
	// register widths and preset values
	// ****************************************
	localparam int OSG_REG_W = 16;
	localparam logic [15:0] OSG_MASK_PRESET = 16'h0000;
	localparam logic [15:0] OSG_FALL_PRESET = 16'h0000;
	localparam logic [15:0] OSG_RISE_PRESET = 16'h7fff;
	// values above 32767 are not storable: bit 15 reads zero except in the condition word
	localparam logic [15:0] OSG_VALUE_LIMIT = 16'h7fff;
	localparam logic [15:0] OSG_ZERO = 16'h0000;
	// position of the negative constant-current flag in the condition word
	localparam int OSG_NEG_CC_BIT = 11;

	// ****************************************
	// host command set
	// ****************************************
	typedef enum logic [3:0] {
		OSG_CMD_READ_COND,
		OSG_CMD_READ_EVENT,
		OSG_CMD_READ_MASK,
		OSG_CMD_WRITE_MASK,
		OSG_CMD_READ_FALL,
		OSG_CMD_WRITE_FALL,
		OSG_CMD_READ_RISE,
		OSG_CMD_WRITE_RISE,
		OSG_CMD_CLEAR_STATUS,
		OSG_CMD_PRESET
	} osg_cmd_code_t;

	// one host request, valid for one cycle
	typedef struct packed {
		logic valid;
		osg_cmd_code_t code;
		logic [15:0] data;
	} osg_cmd_t;

	// one answer to a read request
	typedef struct packed {
		logic valid;
		logic [15:0] data;
	} osg_resp_t;

endpackage

// file: hw/osg_status_group.sv
// operation status register group: live condition, transition filters, event latch, summary
`timescale 1ns/100ps
module osg_status_group
	import osg_pkg::*;
#(
	parameter int WIDTH = OSG_REG_W
) (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [15:0] cond_raw,
	input wire logic neg_cc_raw,
	input wire osg_cmd_t host_cmd,
	output osg_resp_t host_resp,
	output logic operation_summary_bit,
	output logic negative_current_regulation_flag
);

	// ****************************************
	// elaboration check
	// ****************************************
	if (WIDTH != 16) begin : g_bad_width
		$error("osg_status_group only serves a 16-bit register width");
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	// ****************************************
	// condition capture
	// ****************************************
	logic [15:0] cond_meta_reg, cond_meta_next;
	logic [15:0] live_cond_reg, live_cond_next;
	logic [15:0] prev_cond_reg, prev_cond_next;
	logic [15:0] cond_in;

	// external state is asynchronous to core_clk, so two flops first
	always_comb begin
		cond_in = cond_raw;
		cond_in[OSG_NEG_CC_BIT] = neg_cc_raw;
		cond_meta_next = cond_in;
		live_cond_next = cond_meta_reg;
		prev_cond_next = live_cond_reg;
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cond_meta_reg <= OSG_ZERO;
			live_cond_reg <= OSG_ZERO;
			prev_cond_reg <= OSG_ZERO;
		end else begin
			cond_meta_reg <= cond_meta_next;
			live_cond_reg <= live_cond_next;
			prev_cond_reg <= prev_cond_next;
		end
	end

	// ****************************************
	// transition filters
	// ****************************************
	logic [15:0] fall_filter_reg, fall_filter_next;
	logic [15:0] rise_filter_reg, rise_filter_next;
	logic [15:0] mask_reg, mask_next;
	logic [15:0] set_bits;

	// one generate slice per bit; no edge can hit when both filters are 0
	for (genvar i = 0; i < 16; i++) begin : g_edge
		always_comb begin
			set_bits[i] = (fall_filter_reg[i] & prev_cond_reg[i] & ~live_cond_reg[i])
				| (rise_filter_reg[i] & ~prev_cond_reg[i] & live_cond_reg[i]);
		end
	end

	// ****************************************
	// host register writes
	// ****************************************
	function automatic logic is_cmd(input osg_cmd_t c, input osg_cmd_code_t code);
		return c.valid && (c.code == code);
	endfunction

	// bit 15 is dropped so stored values stay within 0..32767
	always_comb begin
		mask_next = mask_reg;
		fall_filter_next = fall_filter_reg;
		rise_filter_next = rise_filter_reg;
		if (is_cmd(host_cmd, OSG_CMD_PRESET)) begin
			mask_next = OSG_MASK_PRESET;
			fall_filter_next = OSG_FALL_PRESET;
			rise_filter_next = OSG_RISE_PRESET;
		end else if (is_cmd(host_cmd, OSG_CMD_WRITE_MASK)) begin
			mask_next = host_cmd.data & OSG_VALUE_LIMIT;
		end else if (is_cmd(host_cmd, OSG_CMD_WRITE_FALL)) begin
			fall_filter_next = host_cmd.data & OSG_VALUE_LIMIT;
		end else if (is_cmd(host_cmd, OSG_CMD_WRITE_RISE)) begin
			rise_filter_next = host_cmd.data & OSG_VALUE_LIMIT;
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			mask_reg <= OSG_MASK_PRESET;
			fall_filter_reg <= OSG_FALL_PRESET;
			rise_filter_reg <= OSG_RISE_PRESET;
		end else begin
			mask_reg <= mask_next;
			fall_filter_reg <= fall_filter_next;
			rise_filter_reg <= rise_filter_next;
		end
	end

	// ****************************************
	// event latch, summary and answers
	// ****************************************
	logic [15:0] event_reg, event_next;
	logic summary_reg, summary_next;
	logic neg_flag_reg, neg_flag_next;
	osg_resp_t resp_reg, resp_next;
	logic clear_events;

	// a new edge in the clearing cycle survives: set wins over clear
	always_comb begin
		clear_events = is_cmd(host_cmd, OSG_CMD_READ_EVENT)
			|| is_cmd(host_cmd, OSG_CMD_CLEAR_STATUS);
		event_next = set_bits | (clear_events ? OSG_ZERO : event_reg);
		summary_next = |(event_next & mask_next);
		neg_flag_next = live_cond_reg[OSG_NEG_CC_BIT];
		resp_next.valid = 1'b0;
		resp_next.data = OSG_ZERO;
		if (host_cmd.valid) begin
			resp_next.valid = 1'b1;
			case (host_cmd.code)
				OSG_CMD_READ_COND: resp_next.data = live_cond_reg;
				OSG_CMD_READ_EVENT: resp_next.data = event_reg;
				OSG_CMD_READ_MASK: resp_next.data = mask_reg;
				OSG_CMD_READ_FALL: resp_next.data = fall_filter_reg;
				OSG_CMD_READ_RISE: resp_next.data = rise_filter_reg;
				default: resp_next.valid = 1'b0; // writes and actions answer nothing
			endcase
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			event_reg <= OSG_ZERO;
			summary_reg <= 1'b0;
			neg_flag_reg <= 1'b0;
			resp_reg <= '0;
		end else begin
			event_reg <= event_next;
			summary_reg <= summary_next;
			neg_flag_reg <= neg_flag_next;
			resp_reg <= resp_next;
		end
	end

	always_comb begin
		host_resp = resp_reg;
		operation_summary_bit = summary_reg;
		negative_current_regulation_flag = neg_flag_reg;
	end

	// ****************************************
	// checks
	// ****************************************
	sequence seq_event_read;
		host_cmd.valid && host_cmd.code == OSG_CMD_READ_EVENT;
	endsequence

	sequence seq_event_answer(logic [15:0] v);
		host_resp.valid && host_resp.data == v;
	endsequence

	chk_cond_query: assert property (
		(host_cmd.valid && host_cmd.code == OSG_CMD_READ_COND)
		|=> host_resp.valid && host_resp.data == $past(live_cond_reg))
		else $error("condition query did not return live state");

	chk_mask_range: assert property (
		mask_reg[15] == 1'b0 && fall_filter_reg[15] == 1'b0 && rise_filter_reg[15] == 1'b0)
		else $error("stored filter or mask value above 32767");

	// look one edge after a sampled reset, so no start-up history is needed
	chk_preset_values: assert property (disable iff (1'b0)
		reset |=> mask_reg == 16'h0000 && fall_filter_reg == 16'h0000
		&& rise_filter_reg == 16'h7fff)
		else $error("preset values wrong after reset");

	chk_fall_latch: assert property (
		(|(fall_filter_reg & prev_cond_reg & ~live_cond_reg))
		|=> (event_reg & $past(fall_filter_reg & prev_cond_reg & ~live_cond_reg))
		== $past(fall_filter_reg & prev_cond_reg & ~live_cond_reg))
		else $error("falling edge did not latch event");

	chk_rise_latch: assert property (
		(|(rise_filter_reg & ~prev_cond_reg & live_cond_reg))
		|=> (event_reg & $past(rise_filter_reg & ~prev_cond_reg & live_cond_reg))
		== $past(rise_filter_reg & ~prev_cond_reg & live_cond_reg))
		else $error("rising edge did not latch event");

	chk_unfiltered_quiet: assert property (
		((event_reg & ~$past(event_reg)) & $past(~(fall_filter_reg | rise_filter_reg))) == 16'h0000)
		else $error("event set with both filters clear");

	chk_event_read: assert property (
		seq_event_read |=> seq_event_answer($past(event_reg))
		##0 event_reg == $past(set_bits))
		else $error("event read did not answer and clear");

	chk_summary_or: assert property (
		##1 operation_summary_bit == |(event_reg & mask_reg))
		else $error("summary bit not OR of enabled events");

	chk_neg_flag: assert property (
		$changed(live_cond_reg[OSG_NEG_CC_BIT])
		|=> negative_current_regulation_flag == $past(live_cond_reg[OSG_NEG_CC_BIT]))
		else $error("negative current flag does not follow condition");

endmodule

// file: test/osg_testbench.sv
// self-checking bench for the operation status register group
`timescale 1ns/100ps
module testbench;
	import osg_pkg::*;

	logic core_clk = 1'b0;
	logic reset = 1'b1;
	logic [15:0] cond_raw = 16'h0000;
	logic neg_cc_raw = 1'b0;
	osg_cmd_t host_cmd = '0;
	osg_resp_t host_resp;
	logic operation_summary_bit;
	logic negative_current_regulation_flag;
	int n_fail = 0;
	int n_compared = 0;
	int cycles = 0;

	osg_status_group osg_status_group_i (
		.core_clk(core_clk),
		.reset(reset),
		.cond_raw(cond_raw),
		.neg_cc_raw(neg_cc_raw),
		.host_cmd(host_cmd),
		.host_resp(host_resp),
		.operation_summary_bit(operation_summary_bit),
		.negative_current_regulation_flag(negative_current_regulation_flag)
	);

	// ****************************************
	// clock, watchdog and helper tasks
	// ****************************************
	always #20 core_clk = ~core_clk;

	// the whole sequence needs about 110 cycles, so this only trips on a hang
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 2000) begin
			n_fail++;
			end_sim();
		end
	end

	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask

	// waits end just after an edge so outputs have settled
	task wt(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	// one-cycle request, launched and dropped on rising edges
	task send(input osg_cmd_code_t c, input logic [15:0] d);
		@(posedge core_clk);
		host_cmd <= '{valid: 1'b1, code: c, data: d};
		@(posedge core_clk);
		host_cmd <= '0;
	endtask

	// answer is registered at the taking edge, so look just after it
	task rd(input osg_cmd_code_t c, input logic [15:0] exp);
		send(c, 16'h0000);
		#1;
		chk({15'h0000, host_resp.valid}, 16'h0001);
		chk(host_resp.data, exp);
	endtask

	// pins change on an edge; event lands three edges later
	task pin(input logic [15:0] c, input logic n);
		@(posedge core_clk);
		cond_raw <= c;
		neg_cc_raw <= n;
		wt(4);
	endtask

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		rd(OSG_CMD_READ_MASK, 16'h0000);
		rd(OSG_CMD_READ_FALL, 16'h0000);
		rd(OSG_CMD_READ_RISE, 16'h7fff);
		rd(OSG_CMD_READ_EVENT, 16'h0000);
		chk({15'h0000, operation_summary_bit}, 16'h0000);
		// bit 15 of a written value is not storable
		send(OSG_CMD_WRITE_MASK, 16'hffff);
		#1;
		chk({15'h0000, host_resp.valid}, 16'h0000);
		rd(OSG_CMD_READ_MASK, 16'h7fff);
		send(OSG_CMD_WRITE_FALL, 16'h8006);
		rd(OSG_CMD_READ_FALL, 16'h0006);
		send(OSG_CMD_WRITE_RISE, 16'h0003);
		rd(OSG_CMD_READ_RISE, 16'h0003);
		send(OSG_CMD_WRITE_MASK, 16'h0000);
		// bit 11 comes only from the regulation input
		pin(16'h0805, 1'b0);
		rd(OSG_CMD_READ_COND, 16'h0005);
		pin(16'h0805, 1'b1);
		rd(OSG_CMD_READ_COND, 16'h0805);
		chk({15'h0000, negative_current_regulation_flag}, 16'h0001);
		rd(OSG_CMD_READ_EVENT, 16'h0001);
		pin(16'h0000, 1'b0);
		chk({15'h0000, negative_current_regulation_flag}, 16'h0000);
		pin(16'h000a, 1'b0);
		rd(OSG_CMD_READ_EVENT, 16'h0006);
		pin(16'h0000, 1'b0);
		send(OSG_CMD_WRITE_MASK, 16'h0001);
		wt(2);
		chk({15'h0000, operation_summary_bit}, 16'h0000);
		send(OSG_CMD_WRITE_MASK, 16'h0002);
		wt(2);
		chk({15'h0000, operation_summary_bit}, 16'h0001);
		rd(OSG_CMD_READ_EVENT, 16'h0002);
		wt(2);
		chk({15'h0000, operation_summary_bit}, 16'h0000);
		rd(OSG_CMD_READ_EVENT, 16'h0000);
		// clear status drops a latched, enabled event
		pin(16'h0002, 1'b0);
		chk({15'h0000, operation_summary_bit}, 16'h0001);
		send(OSG_CMD_CLEAR_STATUS, 16'h0000);
		wt(2);
		chk({15'h0000, operation_summary_bit}, 16'h0000);
		rd(OSG_CMD_READ_EVENT, 16'h0000);
		send(OSG_CMD_PRESET, 16'h0000);
		rd(OSG_CMD_READ_MASK, 16'h0000);
		rd(OSG_CMD_READ_FALL, 16'h0000);
		rd(OSG_CMD_READ_RISE, 16'h7fff);
		// preset rising filter catches entry into negative regulation
		pin(16'h0002, 1'b1);
		send(OSG_CMD_WRITE_MASK, 16'h0800);
		wt(2);
		chk({15'h0000, operation_summary_bit}, 16'h0001);
		rd(OSG_CMD_READ_EVENT, 16'h0800);
		end_sim();
	end
endmodule
